// >>> include/pwm_sensor_regs.vh
// Constants for the PWM field sensor output stage
`ifndef PWM_SENSOR_REGS_VH
`define PWM_SENSOR_REGS_VH
`define CLK_FREQ_HZ        100000000
`define CARRIER_FREQ_HZ    2000
`define POWER_ON_DELAY_US  900
`define DUTY_PERMILLE_ZERO 500
`define DUTY_PERMILLE_LOW  80
`define DUTY_PERMILLE_HIGH 920
`define DUTY_PERMILLE_CLO  60
`define DUTY_PERMILLE_CHI  940
`define DUTY_PERMILLE_FULL 1000
`endif

// >>> verilog/duty_scaler.v
// Maps a signed field code to a clamped duty in permille
`timescale 1ns/10ps
`default_nettype none
`include "pwm_sensor_regs.vh"
module duty_scaler #(
  parameter FIELD_W = 12
) (
  input  wire                      clock,
  input  wire                      rst_int_n,
  input  wire signed [FIELD_W-1:0] field,
  input  wire        [7:0]         gain,
  output reg         [9:0]         duty_r,
  output reg                       linear_r
);
  wire signed [31:0] raw;
  reg         [9:0]  duty_nxt;
  reg                linear_nxt;

  // Signed field scaled by gain, offset about zero-field duty
  assign raw = `DUTY_PERMILLE_ZERO + ($signed({{(32-FIELD_W){field[FIELD_W-1]}}, field})
               * $signed({24'h000000, gain})) / 16; // [R2] [R4]

  // Linear only inside window, clamped outside like the sensor rails
  always @*
  begin
    linear_nxt = 1'b1;
    duty_nxt   = raw[9:0];
    if (raw < `DUTY_PERMILLE_LOW)
    begin
      linear_nxt = 1'b0; // [R3]
      duty_nxt   = 10'd`DUTY_PERMILLE_CLO;
    end
    else if (raw > `DUTY_PERMILLE_HIGH)
    begin
      linear_nxt = 1'b0; // [R3]
      duty_nxt   = 10'd`DUTY_PERMILLE_CHI;
    end
  end

  always @(posedge clock or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      duty_r   <= 10'h1F4;
      linear_r <= 1'b1;
    end
    else
    begin
      duty_r   <= duty_nxt;
      linear_r <= linear_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/pwm_field_sensor.v
// PWM output stage of a linear field sensor
//
// Behaviour
// R1 - Emit one 2 kHz pulse train carrying duty
// R2 - Zero field gives 50 percent duty
// R3 - Linear only between 8 and 92 percent
// R4 - Both polarities give distinct duty values
// R5 - Output invalid during initialization interval
// R6 - Decoder timestamps both edges (far side)
// R7 - Decoder timer much faster than carrier
// R8 - Decoder duty equals high over period
// R9 - Decoder may count high and low ticks
// R10 - Resolution step is carrier over sample rate
// R11 - Power-on ends at first valid rising edge
// R12 - Decoder flags missing edges or saturation; duty_decoder has no flag output, only duty and done
`timescale 1ns/10ps
`default_nettype none
`include "pwm_sensor_regs.vh"
module pwm_field_sensor #(
  parameter FIELD_W        = 12,
  parameter POWER_ON_DELAY = `POWER_ON_DELAY_US * (`CLK_FREQ_HZ / 1000000),
  parameter PERIOD_CYC     = `CLK_FREQ_HZ / `CARRIER_FREQ_HZ
) (
  input  wire                      clock,
  input  wire                      rst_n,
  input  wire signed [FIELD_W-1:0] field,
  input  wire        [7:0]         gain,
  output wire                      out_o,
  output wire                      out_oe,
  output reg                       valid_r,
  output wire                      linear
);
  // Cycles per duty permille step
  localparam STEP_CYC = PERIOD_CYC / `DUTY_PERMILLE_FULL;
  localparam ST_INIT  = 2'b01;
  localparam ST_RUN   = 2'b10;

  reg  [1:0]  rst_sync_r;
  wire        rst_int_n;
  reg  [1:0]  state_r;
  reg  [31:0] init_cnt_r;
  reg  [31:0] step_cnt_r;
  reg  [9:0]  phase_r;
  reg  [9:0]  duty_hold_r;
  reg         high_r;
  wire [9:0]  duty;
  wire        step_tick;

  // Reset release through two flops
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_int_n = rst_sync_r[1];

  duty_scaler #(
    .FIELD_W (FIELD_W)
  ) u_scaler (
    .clock     (clock),
    .rst_int_n (rst_int_n),
    .field     (field),
    .gain      (gain),
    .duty_r    (duty),
    .linear_r  (linear)
  );

  // One-cycle enable per permille of the period
  assign step_tick = (step_cnt_r == STEP_CYC - 1);

  // Power-on hold, then free-running carrier
  always @(posedge clock or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      state_r     <= ST_INIT;
      init_cnt_r  <= 32'h00000000;
      step_cnt_r  <= 32'h00000000;
      phase_r     <= 10'h000;
      duty_hold_r <= 10'h1F4;
      high_r      <= 1'b0;
      valid_r     <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_INIT:
        begin
          high_r <= 1'b0; // [R5]
          if (init_cnt_r == POWER_ON_DELAY - 1)
          begin
            state_r     <= ST_RUN;
            duty_hold_r <= duty;
            high_r      <= 1'b1; // First rising edge ends power-on [R11]
            valid_r     <= 1'b1;
          end
          else
            init_cnt_r <= init_cnt_r + 32'h00000001;
        end
        ST_RUN:
        begin
          step_cnt_r <= step_tick ? 32'h00000000 : step_cnt_r + 32'h00000001;
          if (step_tick)
          begin
            if (phase_r == `DUTY_PERMILLE_FULL - 1)
            begin
              // Duty latched per period so each pulse is self-consistent
              phase_r     <= 10'h000;
              duty_hold_r <= duty;
              high_r      <= 1'b1; // [R1]
            end
            else
            begin
              phase_r <= phase_r + 10'h001;
              if (phase_r + 10'h001 == duty_hold_r)
                high_r <= 1'b0; // [R1] [R2]
            end
          end
        end
        default:
          state_r <= ST_INIT;
      endcase
    end
  end

  // Open drain: pull low only, line high when released
  assign out_o  = 1'b0;
  assign out_oe = ~high_r;
endmodule
`default_nettype wire

// >>> test/pwm_out_chk.sv
// Port checker for the PWM sensor output stage
`timescale 1ns/10ps
`default_nettype none
module pwm_out_chk #(parameter PERIOD_CYC = 2000) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic out_o,
  input wire logic out_oe,
  input wire logic valid_r
);
  localparam S = PERIOD_CYC / 1000;
  int   cnt_r;
  int   hi_r;
  logic seen_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Period and high-span counters, first period ignored since it has no start
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      cnt_r  <= 0;
      hi_r   <= 0;
      seen_r <= 1'b0;
    end
    else
    begin
      hi_r   <= out_oe ? 0 : hi_r + 1;
      cnt_r  <= $fell(out_oe) ? 0 : cnt_r + 1;
      seen_r <= seen_r | $fell(out_oe);
    end
  chk_drive_low: assert property (out_o == 1'b0) else $error("out_o high");
  chk_held_low: assert property (!valid_r |-> out_oe) else $error("early release");
  chk_valid_stays: assert property (valid_r |=> valid_r) else $error("valid lost");
  chk_first_edge: assert property ($rose(valid_r) |-> !out_oe)
    else $error("no first edge");
  chk_period_len: assert property ($fell(out_oe) && seen_r |-> cnt_r == PERIOD_CYC - 1)
    else $error("bad period");
  chk_high_span: assert property ($rose(out_oe) && seen_r |-> hi_r inside {[S*60:S*940]})
    else $error("duty outside clamp");
  cover property ($rose(valid_r));
  cover property ($rose(out_oe) && hi_r == S*940);
  cover property ($rose(out_oe) && hi_r == S*60);
endmodule
bind pwm_field_sensor pwm_out_chk #(.PERIOD_CYC(PERIOD_CYC)) i_pwm_out_chk (
  .clock(clock), .rst_n(rst_n), .out_o(out_o), .out_oe(out_oe), .valid_r(valid_r));
`default_nettype wire

// >>> test/duty_decoder.sv
// Far-side decoder model counting line ticks per period
`timescale 1ns/10ps
`default_nettype none
module duty_decoder (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        line,
  output var  logic [31:0] duty,
  output var  logic        done
);
  int   hi;
  int   lo;
  logic prev;
  // One tick a clock, so the step is 1000 over the period in permille
  always @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      hi <= 0;
      lo <= 0;
      prev <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      prev <= line;
      // Rising edge closes a period; the power-on stretch has no high ticks
      if (line && !prev)
      begin
        if (hi > 0)
        begin
          duty <= hi * 1000 / (hi + lo);
          done <= 1'b1;
        end
        hi <= 1;
        lo <= 0;
      end
      else if (line)
        hi <= hi + 1;
      else
        lo <= lo + 1;
    end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Bench for the PWM sensor output stage
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock, rst_n, out_o, out_oe, valid_r, linear, done;
  logic signed [11:0] field;
  logic [7:0] gain;
  logic [31:0] duty, seed;
  int n_errors, checks_done, cyc, i;
  int tab[7] = '{0, 300, -300, 420, 421, -420, -421};
  wire logic line = out_oe ? out_o : 1'b1; // Pull-up when released
  pwm_field_sensor #(.POWER_ON_DELAY(20), .PERIOD_CYC(2000)) i_pwm_field_sensor (
    .clock(clock), .rst_n(rst_n), .field(field), .gain(gain), .out_o(out_o),
    .out_oe(out_oe), .valid_r(valid_r), .linear(linear));
  duty_decoder i_duty_decoder (
    .clock(clock), .rst_n(rst_n), .line(line), .duty(duty), .done(done));
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task chk(string s, logic [31:0] e, logic [31:0] v);
    checks_done++;
    if (v !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %0d seen %0d", s, e, v);
    end
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Third report is sure to cover a whole period at the new field
  task run(int f, int g);
    int d, k, n;
    @(posedge clock);
    field <= f[11:0];
    gain <= g[7:0];
    n = 0;
    for (k = 0; k < 9000 && n < 3; k++)
    begin
      @(negedge clock);
      n += int'(done);
    end
    d = 500 + f * g / 16;
    chk("reports", 3, n);
    chk("linear", (d >= 80 && d <= 920), {31'h0, linear});
    d = d < 80 ? 60 : (d > 920 ? 940 : d);
    chk("duty", d, duty);
  endtask
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_errors++;
      give_verdict;
    end
  end
  initial
  begin
    rst_n = 1'b0;
    field = 12'h000;
    gain = 8'h10;
    seed = 32'h4891;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk("valid", 0, {31'h0, valid_r});
    foreach (tab[i]) run(tab[i], 16);
    for (i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      run(int'(seed[12:4] % 451) - 225, 16 << seed[0]);
    end
    give_verdict;
  end
endmodule
`default_nettype wire
